/* inc/alert_rate_pkg.sv */
// Register map, field layout, reset values and timing counts of the alert mask and conversion rate block.
package alert_rate_pkg;

   // Register offsets.
   localparam logic [7:0] REG_CONV_RATE_RD   = 8'h04;
   localparam logic [7:0] REG_CONV_RATE_WR   = 8'h0A;
   localparam logic [7:0] REG_ONE_SHOT       = 8'h0F;
   localparam logic [7:0] REG_ALERT_MASK     = 8'h16;

   // Reset values and fixed fields.
   localparam logic [7:0] CONV_RATE_RESET    = 8'h08;
   localparam logic [7:0] RATE_CODE_MAX      = 8'h09;
   localparam logic [7:0] ALERT_MASK_RESET   = 8'h00;
   localparam logic [7:0] ALERT_MASK_ONES    = 8'hA4;
   localparam logic [7:0] ALERT_MASK_WRITE   = 8'h5B;
   localparam logic [7:0] READ_UNMAPPED      = 8'h00;

   // Mask bit positions.
   localparam int unsigned MASK_LOCAL_HIGH   = 6;
   localparam int unsigned MASK_REMOTE_HIGH  = 4;
   localparam int unsigned MASK_REMOTE_LOW   = 3;
   localparam int unsigned MASK_CRIT_LIMIT   = 1;
   localparam int unsigned MASK_FAN_SPEED    = 0;

   // Timing: the fastest conversion period in microseconds and its cycle count.
   localparam int unsigned CLOCK_FREQ_MHZ        = 100;
   localparam int unsigned FASTEST_PERIOD_US     = 31250;
   localparam int unsigned FASTEST_PERIOD_CYCLES = FASTEST_PERIOD_US * CLOCK_FREQ_MHZ;

   // Alarm sources that may drive the alert output.
   typedef struct packed {
      logic local_high;
      logic remote_high;
      logic remote_low;
      logic critical_temp_limit;
      logic fan_speed;
   } alarm_bus_t;

   // Register access strobes with address and write data.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Conversion scheduler states.
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_conv = 2'b10
   } conv_state_t;

endpackage

/* hw/conversion_timer.sv */
// Periodic conversion tick generator driven by the conversion rate code.
`timescale 1ns/1ps
`default_nettype none
module conversion_timer
   import alert_rate_pkg::*;
#(
   parameter int unsigned FAST_PERIOD_CYCLES = FASTEST_PERIOD_CYCLES
)
(
   // Clock and reset.
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   // Control.
   input  wire logic       i_run,
   input  wire logic [7:0] i_rate_code,
   // Tick.
   output var  logic       o_tick_q
);

   logic [7:0]  code_clamped;
   logic [3:0]  shift_amt;
   logic [31:0] period;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        tick_d;

   // ****************************************
   // Period selection
   // ****************************************
   always_comb
   begin
      code_clamped = (i_rate_code > RATE_CODE_MAX) ? RATE_CODE_MAX : i_rate_code; // RULE8
      shift_amt    = 4'(RATE_CODE_MAX - code_clamped); // RULE7 RULE10
      period       = 32'(FAST_PERIOD_CYCLES) << shift_amt; // RULE7
   end

   // ****************************************
   // Counter
   // ****************************************
   always_comb
   begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!i_run)
      begin
         cnt_d = 32'h0000_0000;
      end
      else if (cnt_q >= period - 32'h0000_0001)
      begin
         cnt_d  = 32'h0000_0000;
         tick_d = 1'b1;
      end
      else
      begin
         cnt_d = cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_q    <= 32'h0000_0000;
         o_tick_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         o_tick_q <= tick_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_rate_double;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_rate_code < RATE_CODE_MAX) |-> (period == (32'(FAST_PERIOD_CYCLES) << (4'(RATE_CODE_MAX - i_rate_code))));
   endproperty
   a_rate_double : assert property (p_rate_double) else $error("Period does not follow rate code."); // RULE7

   property p_rate_fastest;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_rate_code >= RATE_CODE_MAX) |-> (period == 32'(FAST_PERIOD_CYCLES));
   endproperty
   a_rate_fastest : assert property (p_rate_fastest) else $error("High rate code not fastest."); // RULE8

   property p_rate_two_hz;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_rate_code == 8'h05) |-> (period == (32'(FAST_PERIOD_CYCLES) << 4));
   endproperty
   a_rate_two_hz : assert property (p_rate_two_hz) else $error("Code 5 is not 2 Hz."); // RULE10

   property p_tick_spacing;
      @(posedge i_clock) disable iff (!i_nrst)
      (o_tick_q && i_run) |-> (cnt_q == 32'h0000_0000);
   endproperty
   a_tick_spacing : assert property (p_tick_spacing) else $error("Tick without counter restart."); // RULE7

endmodule
`default_nettype wire

/* hw/alert_mask_conversion_rate.sv */
// Alert masking, conversion rate register and one-shot conversion scheduling.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Local high alarm reaches alert only while mask bit 6 is clear.
// RULE2: Remote high alarm reaches alert only while mask bit 4 is clear.
// RULE3: Remote low alarm reaches alert only while mask bit 3 is clear.
// RULE4: Critical limit alarm reaches alert only while mask bit 1 is clear.
// RULE5: Fan speed alarm reaches alert only while mask bit 0 is clear.
// RULE6: Mask bits 5 and 2 always read as one.
// RULE7: Rate code 0 slowest, each step doubles to code 9; reset code is 16 Hz.
// RULE8: Codes above 9 convert at the fastest rate, 32 Hz.
// RULE9: In standby, one write to the one-shot register starts exactly one conversion.
// RULE10: Code 5 gives 2 Hz and code 6 gives 4 Hz.
module alert_mask_conversion_rate
   import alert_rate_pkg::*;
#(
   parameter int unsigned FAST_PERIOD_CYCLES = FASTEST_PERIOD_CYCLES
)
(
   // Clock and reset.
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   // Register access.
   input  wire reg_req_t   i_reg,
   output var  logic [7:0] o_rdata_q,
   // Alarm sources and alert.
   input  wire alarm_bus_t i_alarm,
   output var  logic       o_alert_q,
   // Conversion control.
   input  wire logic       i_standby,
   input  wire logic       i_conv_done,
   output var  logic       o_conv_start_q,
   output var  logic       o_conv_busy
);

   logic [7:0]  rate_q;
   logic [7:0]  rate_d;
   logic [7:0]  mask_q;
   logic [7:0]  mask_d;
   logic [7:0]  rdata_d;
   logic [7:0]  mask_read;
   logic        alert_d;
   logic        tick;
   logic        pending_q;
   logic        pending_d;
   logic        start_d;
   logic        take;
   logic        wr_one_shot;
   conv_state_t state_q;
   conv_state_t state_d;

   // ****************************************
   // Register file
   // ****************************************
   always_comb
   begin
      mask_read = mask_q | ALERT_MASK_ONES; // RULE6
      rate_d    = rate_q;
      mask_d    = mask_q;
      rdata_d   = o_rdata_q;
      if (i_reg.wr && (i_reg.addr == REG_CONV_RATE_WR || i_reg.addr == REG_CONV_RATE_RD))
      begin
         rate_d = i_reg.wdata; // RULE7
      end
      if (i_reg.wr && i_reg.addr == REG_ALERT_MASK)
      begin
         mask_d = i_reg.wdata & ALERT_MASK_WRITE; // RULE6
      end
      if (i_reg.rd)
      begin
         case (i_reg.addr)
            REG_CONV_RATE_RD : rdata_d = rate_q;
            REG_ALERT_MASK   : rdata_d = mask_read;
            default          : rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rate_q    <= CONV_RATE_RESET;
         mask_q    <= ALERT_MASK_RESET;
         o_rdata_q <= READ_UNMAPPED;
      end
      else
      begin
         rate_q    <= rate_d;
         mask_q    <= mask_d;
         o_rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Alert masking
   // ****************************************
   always_comb
   begin
      alert_d = (i_alarm.local_high && !mask_q[MASK_LOCAL_HIGH]) // RULE1
             || (i_alarm.remote_high && !mask_q[MASK_REMOTE_HIGH]) // RULE2
             || (i_alarm.remote_low && !mask_q[MASK_REMOTE_LOW]) // RULE3
             || (i_alarm.critical_temp_limit && !mask_q[MASK_CRIT_LIMIT]) // RULE4
             || (i_alarm.fan_speed && !mask_q[MASK_FAN_SPEED]); // RULE5
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_alert_q <= 1'b0;
      end
      else
      begin
         o_alert_q <= alert_d;
      end
   end

   // ****************************************
   // Conversion scheduling
   // ****************************************
   conversion_timer #(
      .FAST_PERIOD_CYCLES (FAST_PERIOD_CYCLES)
   ) u_timer (
      .i_clock     (i_clock),
      .i_nrst      (i_nrst),
      .i_run       (!i_standby),
      .i_rate_code (rate_q),
      .o_tick_q    (tick)
   );

   assign o_conv_busy = (state_q == st_conv);

   always_comb
   begin
      wr_one_shot = i_reg.wr && (i_reg.addr == REG_ONE_SHOT) && i_standby; // RULE9
      take        = (state_q == st_idle) && pending_q;
      pending_d   = (pending_q && !take) || wr_one_shot; // RULE9
      state_d     = state_q;
      start_d     = 1'b0;
      case (state_q)
         st_idle :
         begin
            if (pending_q || (tick && !i_standby))
            begin
               state_d = st_conv;
               start_d = 1'b1;
            end
         end
         st_conv :
         begin
            if (i_conv_done)
            begin
               state_d = st_idle;
            end
         end
         default :
         begin
            state_d = st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_q        <= st_idle;
         pending_q      <= 1'b0;
         o_conv_start_q <= 1'b0;
      end
      else
      begin
         state_q        <= state_d;
         pending_q      <= pending_d;
         o_conv_start_q <= start_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_local_high;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm.local_high && !mask_q[MASK_LOCAL_HIGH]) |=> o_alert_q;
   endproperty
   a_local_high : assert property (p_local_high) else $error("Local high alarm lost."); // RULE1

   property p_remote_high;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm.remote_high && !mask_q[MASK_REMOTE_HIGH]) |=> o_alert_q;
   endproperty
   a_remote_high : assert property (p_remote_high) else $error("Remote high alarm lost."); // RULE2

   property p_remote_low;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm.remote_low && !mask_q[MASK_REMOTE_LOW]) |=> o_alert_q;
   endproperty
   a_remote_low : assert property (p_remote_low) else $error("Remote low alarm lost."); // RULE3

   property p_crit_limit;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm.critical_temp_limit && !mask_q[MASK_CRIT_LIMIT]) |=> o_alert_q;
   endproperty
   a_crit_limit : assert property (p_crit_limit) else $error("Critical limit alarm lost."); // RULE4

   property p_fan_speed;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm.fan_speed && !mask_q[MASK_FAN_SPEED]) |=> o_alert_q;
   endproperty
   a_fan_speed : assert property (p_fan_speed) else $error("Fan speed alarm lost."); // RULE5

   property p_masked_quiet;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_alarm == '0 || (mask_q & ALERT_MASK_WRITE) == ALERT_MASK_WRITE) |=> !o_alert_q;
   endproperty
   a_masked_quiet : assert property (p_masked_quiet) else $error("Alert without unmasked alarm."); // RULE1

   property p_fixed_ones;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_reg.rd && i_reg.addr == REG_ALERT_MASK) |=> (o_rdata_q[5] && o_rdata_q[2]);
   endproperty
   a_fixed_ones : assert property (p_fixed_ones) else $error("Unused mask bits not one."); // RULE6

   property p_rate_readback;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_reg.wr && i_reg.addr == REG_CONV_RATE_WR) ##1 (i_reg.rd && i_reg.addr == REG_CONV_RATE_RD && !i_reg.wr)
         |=> (o_rdata_q == $past(i_reg.wdata, 2));
   endproperty
   a_rate_readback : assert property (p_rate_readback) else $error("Rate code not held."); // RULE7

   property p_one_shot;
      @(posedge i_clock) disable iff (!i_nrst)
      (i_reg.wr && i_reg.addr == REG_ONE_SHOT && i_standby && !pending_q && state_q == st_idle)
         |=> ##1 o_conv_start_q;
   endproperty
   a_one_shot : assert property (p_one_shot) else $error("One-shot did not start."); // RULE9

   property p_standby_single;
      @(posedge i_clock) disable iff (!i_nrst)
      (o_conv_start_q && $past(i_standby) && $past(i_standby, 2)) |-> $past(pending_q);
   endproperty
   a_standby_single : assert property (p_standby_single) else $error("Standby start without one-shot."); // RULE9

   c_one_shot : cover property (@(posedge i_clock) disable iff (!i_nrst) i_standby && o_conv_start_q);
   c_periodic : cover property (@(posedge i_clock) disable iff (!i_nrst) !i_standby && o_conv_start_q);
   c_alert    : cover property (@(posedge i_clock) disable iff (!i_nrst) $rose(o_alert_q));
   c_done     : cover property (@(posedge i_clock) disable iff (!i_nrst) o_conv_busy && i_conv_done);

endmodule
`default_nettype wire

/* testbench/reg_host_model.sv */
// Host model that pulses register accesses and a converter that ends each conversion.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
   import alert_rate_pkg::*;
(
   // Clock.
   input  wire logic       i_clock,
   // Design side.
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_conv_start,
   input  wire logic [7:0] i_conv_delay,
   output var  reg_req_t   o_reg,
   output var  logic       o_conv_done
);
   initial
   begin
      o_reg       = '0;
      o_conv_done = 1'b0;
   end
   // Released address and data show the inverse of the last value.
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
      @(negedge i_clock);
      o_reg = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
      @(negedge i_clock);
      o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
   endtask
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] wdata);
      access(1'b1, addr, wdata);
   endtask
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] rdata);
      access(1'b0, addr, 8'h00);
      @(negedge i_clock);
      rdata = i_rdata;
   endtask
   // Write followed at once by a read, with no idle cycle between them.
   task automatic write_then_read(input logic [7:0] waddr, input logic [7:0] wdata, input logic [7:0] raddr,
                                  output logic [7:0] rdata);
      @(negedge i_clock);
      o_reg = '{wr: 1'b1, rd: 1'b0, addr: waddr, wdata: wdata};
      @(negedge i_clock);
      o_reg = '{wr: 1'b0, rd: 1'b1, addr: raddr, wdata: ~wdata};
      @(negedge i_clock);
      o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~raddr, wdata: wdata};
      rdata = i_rdata;
   endtask
   // Converter ends each started conversion after the set number of cycles.
   always
   begin
      @(negedge i_clock);
      if (i_conv_start === 1'b1)
      begin
         repeat (i_conv_delay) @(negedge i_clock);
         o_conv_done = 1'b1;
         @(negedge i_clock);
         o_conv_done = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_alert_mask_conversion_rate.sv */
// Self-checking bench of the alert mask and conversion rate block.
`timescale 1ns/1ps
`default_nettype none
module tb_alert_mask_conversion_rate
   import alert_rate_pkg::*;
;
   // ****************************************
   // Signals and instances.
   // ****************************************
   localparam int unsigned FAST = 8;
   typedef struct packed {
      logic [7:0] mask;
      alarm_bus_t alarm;
      logic       alert;
   } row_t;
   localparam row_t ROWS [0:11] = '{
      '{8'h00, 5'h10, 1'b1}, '{8'h40, 5'h10, 1'b0}, '{8'h00, 5'h08, 1'b1}, '{8'h10, 5'h08, 1'b0},
      '{8'h00, 5'h04, 1'b1}, '{8'h08, 5'h04, 1'b0}, '{8'h00, 5'h02, 1'b1}, '{8'h02, 5'h02, 1'b0},
      '{8'h00, 5'h01, 1'b1}, '{8'h01, 5'h01, 1'b0}, '{8'h5B, 5'h1F, 1'b0}, '{8'hA4, 5'h1F, 1'b1}};
   logic       clock;
   logic       nrst;
   reg_req_t   reg_req;
   logic [7:0] rdata;
   alarm_bus_t alarm;
   logic       alert;
   logic       standby;
   logic       conv_done;
   logic       conv_start;
   logic       conv_busy;
   logic [7:0] conv_delay;
   int         fail_count = 0;
   int         compares = 0;
   int         cycles = 0;

   alert_mask_conversion_rate #(.FAST_PERIOD_CYCLES(FAST)) alert_mask_conversion_rate_i (
      .i_clock        (clock),
      .i_nrst         (nrst),
      .i_reg          (reg_req),
      .o_rdata_q      (rdata),
      .i_alarm        (alarm),
      .o_alert_q      (alert),
      .i_standby      (standby),
      .i_conv_done    (conv_done),
      .o_conv_start_q (conv_start),
      .o_conv_busy    (conv_busy)
   );
   reg_host_model reg_host_model_i (
      .i_clock      (clock),
      .i_rdata      (rdata),
      .i_conv_start (conv_start),
      .i_conv_delay (conv_delay),
      .o_reg        (reg_req),
      .o_conv_done  (conv_done)
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ****************************************
   // Tasks.
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_start(output int n);
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (conv_start !== 1'b1 && n < 10000);
   endtask
   task automatic count_starts(input int len, output int k);
      k = 0;
      repeat (len)
      begin
         @(negedge clock);
         if (conv_start === 1'b1)
            k++;
      end
   endtask
   task automatic reset_reads(input string what);
      logic [7:0] rd;
      check({15'h0, alert}, 16'h0, "alert after reset");
      check({14'h0, conv_start, conv_busy}, 16'h0, "conversion after reset");
      reg_host_model_i.read_reg(REG_CONV_RATE_RD, rd);
      check({8'h0, rd}, {8'h0, CONV_RATE_RESET}, "rate reset");
      reg_host_model_i.read_reg(REG_ALERT_MASK, rd);
      check({8'h0, rd}, {8'h0, ALERT_MASK_ONES}, "mask reset");
      reg_host_model_i.read_reg(REG_ONE_SHOT, rd);
      check({8'h0, rd}, {8'h0, READ_UNMAPPED}, "one-shot read");
      reg_host_model_i.read_reg(REG_CONV_RATE_WR, rd);
      check({8'h0, rd}, {8'h0, READ_UNMAPPED}, "unmapped read");
      $display("test %s done", what);
   endtask
   task automatic complete_run();
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         $display("unexpected at %0t: run too long", $time);
         complete_run();
      end
   end

   // ****************************************
   // Main sequence.
   // ****************************************
   initial
   begin
      logic [7:0] rd;
      logic [7:0] code;
      int         n;
      int         k;
      int         exp;
      nrst       = 1'b0;
      alarm      = '0;
      standby    = 1'b1;
      conv_delay = 8'd2;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      reset_reads("reset");
      foreach (ROWS[r])
      begin
         reg_host_model_i.write_reg(REG_ALERT_MASK, ROWS[r].mask);
         alarm = ROWS[r].alarm;
         reg_host_model_i.read_reg(REG_ALERT_MASK, rd);
         check({8'h0, rd}, {8'h0, (ROWS[r].mask & ALERT_MASK_WRITE) | ALERT_MASK_ONES}, "mask");
         check({15'h0, alert}, {15'h0, ROWS[r].alert}, "alert");
      end
      $display("test mask rows done");
      alarm   = '0;
      standby = 1'b0;
      for (int c = 0; c <= 11; c++)
      begin
         code = (c == 11) ? 8'hFF : c[7:0];
         if (c % 2 == 1)
         begin
            reg_host_model_i.write_then_read(REG_CONV_RATE_WR, code, REG_CONV_RATE_RD, rd);
         end
         else
         begin
            reg_host_model_i.write_reg(REG_CONV_RATE_RD, code);
            reg_host_model_i.read_reg(REG_CONV_RATE_RD, rd);
         end
         check({8'h0, rd}, {8'h0, code}, "rate readback");
         exp = (code > 8'h09) ? FAST : (FAST << (9 - code));
         wait_start(n);
         wait_start(n);
         check(n[15:0], exp[15:0], "conversion period");
      end
      $display("test rate codes done");
      standby = 1'b1;
      repeat (20) @(negedge clock);
      reg_host_model_i.write_reg(REG_ONE_SHOT, 8'h5A);
      count_starts(40, k);
      check(k[15:0], 16'h1, "one-shot starts");
      conv_delay = 8'd20;
      reg_host_model_i.write_reg(REG_ONE_SHOT, 8'h00);
      wait_start(n);
      check({15'h0, conv_busy}, 16'h1, "busy with start");
      reg_host_model_i.write_reg(REG_ONE_SHOT, 8'hFF);
      count_starts(60, k);
      check(k[15:0], 16'h1, "one-shot held over busy");
      $display("test one-shot done");
      reg_host_model_i.write_reg(REG_CONV_RATE_RD, 8'h03);
      standby = 1'b0;
      reg_host_model_i.write_reg(REG_ONE_SHOT, 8'h11);
      count_starts(40, k);
      check(k[15:0], 16'h0, "one-shot outside standby");
      $display("test refused one-shot done");
      reg_host_model_i.write_reg(REG_ALERT_MASK, 8'h5B);
      nrst = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      reset_reads("second reset");
      complete_run();
   end
endmodule
`default_nettype wire
